// >>> design/binary_telegram_framer_crc16.sv
// binary object-access telegram framer with crc16, receive and send
// assumes byte-level serial logic on the same clock, and a command side
// that decodes objects and answers with ack, nak or data
//
// What this block does
// - response start code: low two bits give type, bit 3 is zero
// - requests up to 256 data bytes, responses up to 253
// - every telegram protected by ccitt crc16, polynomial 0x1021 table
// - after a start code, a gap over 5 ms between bytes times out
// - completed write answered 0x06, length 1, two zero bytes, crc
// - refused access answered 0x07, length 1, error hi then lo, crc
// - readable request answered 0x05, length, values in order, crc
// - object without read access answered with the nak telegram
// - crc accumulator cleared to zero at start of every telegram
// - crc step: table[crc>>8 & 0xFF] ^ crc<<8 ^ byte, 16 bits
// - crc appended last, high byte then low byte
// - received crc recomputed, mismatch flags a crc error
// - length byte holds number of data bytes minus one
// - request start code bits 7..4 give type, bit 2 always one
// - request bit 0 set means an address byte follows
`default_nettype none
`include "framer_params.svh"
module binary_telegram_framer_crc16 #(
	parameter int TMO_CYCLES = `FR_TMO_CYC
) (
	input wire logic i_mclk, // system clock
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic i_rx_valid, // received byte strobe
	input wire logic [7:0] i_rx_byte, // received byte
	output framer_pkg::rx_out_t o_rx, // parsed request stream
	input wire framer_pkg::tx_req_t i_tx_req, // answer request
	input wire logic [7:0] i_tx_data, // current data byte of a rsp
	output logic o_tx_next, // pulse: present next data byte
	output logic o_tx_busy, // answer in progress
	output logic o_tx_valid, // byte to serial logic valid
	output logic [7:0] o_tx_byte, // byte to serial logic
	input wire logic i_tx_ready // serial logic takes byte
);
	import framer_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	state_t st_reg;
	state_t st_next;
	logic [15:0] rx_crc_upd;
	logic [15:0] tx_crc_upd;
	logic tx_take;
	logic [7:0] tx_data_byte;
	logic [7:0] tx_len_lim;

	assign rx_crc_upd = crc_upd(st_reg.rx_crc, i_rx_byte);
	assign tx_crc_upd = crc_upd(st_reg.tx_crc, st_reg.tx_byte);
	assign tx_take = (st_reg.tx_st != TX_IDLE) && i_tx_ready;
	assign tx_len_lim = (i_tx_req.len > `FR_RSP_MAX_LEN) ?
		`FR_RSP_MAX_LEN : i_tx_req.len;

	// data byte for the next slot; slot 0 is loaded from TX_LEN
	always_comb begin
		unique case (st_reg.tx_kind)
			KIND_ACK: tx_data_byte = 8'h00;
			KIND_NAK: tx_data_byte = (st_reg.tx_st == TX_LEN) ?
				st_reg.tx_err[15:8] : st_reg.tx_err[7:0];
			default: tx_data_byte = i_tx_data;
		endcase
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.rx_out.strobe = 1'b0;
		st_next.rx_out.done = 1'b0;
		st_next.rx_out.timeout = 1'b0;
		st_next.tx_next = 1'b0;

		// receive side
		if (st_reg.rx_st != RX_IDLE) begin
			st_next.tmo_cnt = st_reg.tmo_cnt + 16'h0001;
		end
		if (i_rx_valid) begin
			st_next.tmo_cnt = 16'h0000;
			unique case (st_reg.rx_st)
				RX_IDLE: begin
					if (((i_rx_byte[7:4] == `FR_TYPE_READ) ||
						(i_rx_byte[7:4] == `FR_TYPE_WRITE)) &&
						i_rx_byte[`FR_SC_ONE_BIT]) begin
						st_next.rx_crc = crc_upd(`FR_CRC_INIT,
							i_rx_byte);
						st_next.rx_out.is_write =
							(i_rx_byte[7:4] == `FR_TYPE_WRITE);
						st_next.rx_out.addr = 8'h00;
						st_next.rx_st = i_rx_byte[`FR_SC_ADDR_BIT] ?
							RX_ADDR : RX_LEN;
					end
				end
				RX_ADDR: begin
					st_next.rx_crc = rx_crc_upd;
					st_next.rx_out.addr = i_rx_byte;
					st_next.rx_st = RX_LEN;
				end
				RX_LEN: begin
					st_next.rx_crc = rx_crc_upd;
					st_next.rx_len = i_rx_byte;
					st_next.rx_cnt = 8'h00;
					st_next.rx_st = RX_DATA;
				end
				RX_DATA: begin
					// 8-bit length bounds a request to 256 bytes
					st_next.rx_crc = rx_crc_upd;
					st_next.rx_out.strobe = 1'b1;
					st_next.rx_out.data = i_rx_byte;
					st_next.rx_cnt = st_reg.rx_cnt + 8'h01;
					if (st_reg.rx_cnt == st_reg.rx_len) begin
						st_next.rx_st = RX_CRCH;
					end
				end
				RX_CRCH: begin
					st_next.rx_chk_hi = i_rx_byte;
					st_next.rx_st = RX_CRCL;
				end
				RX_CRCL: begin
					st_next.rx_out.done = 1'b1;
					st_next.rx_out.crc_err = ({st_reg.rx_chk_hi, i_rx_byte}
						!= st_reg.rx_crc);
					st_next.rx_st = RX_IDLE;
				end
				default: st_next.rx_st = RX_IDLE;
			endcase
		end else if ((st_reg.rx_st != RX_IDLE) &&
			(st_reg.tmo_cnt >= 16'(TMO_CYCLES))) begin
			st_next.rx_out.timeout = 1'b1;
			st_next.rx_st = RX_IDLE;
			st_next.tmo_cnt = 16'h0000;
		end

		// send side
		unique case (st_reg.tx_st)
			TX_IDLE: begin
				if (i_tx_req.start) begin
					st_next.tx_kind = i_tx_req.kind;
					st_next.tx_err = i_tx_req.err;
					st_next.tx_crc = `FR_CRC_INIT;
					st_next.tx_st = TX_SC;
					unique case (i_tx_req.kind)
						KIND_ACK: begin
							st_next.tx_byte = `FR_SC_ACK;
							st_next.tx_len = `FR_ACK_LEN;
						end
						KIND_NAK: begin
							st_next.tx_byte = `FR_SC_NAK;
							st_next.tx_len = `FR_ACK_LEN;
						end
						default: begin
							st_next.tx_kind = KIND_RSP;
							st_next.tx_byte = `FR_SC_RSP;
							st_next.tx_len = tx_len_lim;
						end
					endcase
				end
			end
			TX_SC: if (tx_take) begin
				st_next.tx_crc = tx_crc_upd;
				st_next.tx_byte = st_reg.tx_len;
				st_next.tx_st = TX_LEN;
			end
			TX_LEN: if (tx_take) begin
				st_next.tx_crc = tx_crc_upd;
				st_next.tx_cnt = 8'h00;
				st_next.tx_byte = tx_data_byte;
				st_next.tx_next = (st_reg.tx_kind == KIND_RSP);
				st_next.tx_st = TX_DATA;
			end
			TX_DATA: if (tx_take) begin
				st_next.tx_crc = tx_crc_upd;
				if (st_reg.tx_cnt == st_reg.tx_len) begin
					st_next.tx_byte = tx_crc_upd[15:8];
					st_next.tx_st = TX_CRCH;
				end else begin
					st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
					st_next.tx_byte = tx_data_byte;
					st_next.tx_next = (st_reg.tx_kind == KIND_RSP);
				end
			end
			TX_CRCH: if (tx_take) begin
				st_next.tx_byte = st_reg.tx_crc[7:0];
				st_next.tx_st = TX_CRCL;
			end
			TX_CRCL: if (tx_take) begin
				st_next.tx_st = TX_IDLE;
			end
			default: st_next.tx_st = TX_IDLE;
		endcase
		// busy and valid registered so the outputs come from a flop
		st_next.tx_act = (st_next.tx_st != TX_IDLE);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rx = st_reg.rx_out;
	assign o_tx_next = st_reg.tx_next;
	assign o_tx_busy = st_reg.tx_act;
	assign o_tx_valid = st_reg.tx_act;
	assign o_tx_byte = st_reg.tx_byte;

	// ****************************************************************
	// checks
	// ****************************************************************
	sc_code_form_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_SC |-> !o_tx_byte[`FR_SC_DIR_BIT] &&
		o_tx_byte[`FR_SC_ONE_BIT] && o_tx_byte[7:4] == 4'h0)
		else $error("bad response start code");
	rsp_len_bound_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_LEN |-> o_tx_byte <= `FR_RSP_MAX_LEN)
		else $error("response length too large");
	crc_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_SC |-> st_reg.tx_crc == 16'h0000)
		else $error("crc not cleared at telegram start");
	crc_hi_order_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_CRCH && tx_take |=>
		o_tx_byte == st_reg.tx_crc[7:0] && st_reg.tx_st == TX_CRCL)
		else $error("crc low byte not after high byte");
	ack_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_DATA && st_reg.tx_kind == KIND_ACK |->
		o_tx_byte == 8'h00 && st_reg.tx_len == 8'h01)
		else $error("ack data not zero");
	nak_err_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.tx_st == TX_DATA && st_reg.tx_kind == KIND_NAK &&
		st_reg.tx_cnt == 8'h00 |-> o_tx_byte == st_reg.tx_err[15:8])
		else $error("nak error high byte wrong");
	timeout_drop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.rx_out.timeout |-> st_reg.rx_st == RX_IDLE &&
		!st_reg.rx_out.done && !o_tx_valid ##1 !st_reg.rx_out.done)
		else $error("timeout did not drop telegram");
	timeout_when_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(st_reg.rx_out.timeout) |->
		$past(st_reg.tmo_cnt) >= 16'(TMO_CYCLES))
		else $error("timeout fired early");
	crc_check_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.rx_st == RX_CRCL && i_rx_valid |=> st_reg.rx_out.done &&
		st_reg.rx_out.crc_err == ($past({st_reg.rx_chk_hi, i_rx_byte})
		!= $past(st_reg.rx_crc)))
		else $error("crc check result wrong");
	addr_skip_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		st_reg.rx_st == RX_IDLE && i_rx_valid && i_rx_byte[2] &&
		i_rx_byte[7:4] == `FR_TYPE_READ |=>
		st_reg.rx_st == ($past(i_rx_byte[0]) ? RX_ADDR : RX_LEN))
		else $error("address byte handling wrong");
endmodule : binary_telegram_framer_crc16
`default_nettype wire

// >>> design/framer_params.svh
// constants of the binary telegram framer: codes, bit positions, timing
// assumes a single 10 MHz system clock
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH
`define FR_TYPE_READ 4'hA
`define FR_TYPE_WRITE 4'hC
`define FR_SC_RSP 8'h05
`define FR_SC_ACK 8'h06
`define FR_SC_NAK 8'h07
`define FR_SC_ADDR_BIT 0
`define FR_SC_ONE_BIT 2
`define FR_SC_DIR_BIT 3
`define FR_ACK_LEN 8'h01
`define FR_RSP_MAX_LEN 8'hFC
`define FR_CRC_INIT 16'h0000
`define FR_CRC_POLY 16'h1021
`define FR_CLK_NS 100
`define FR_TMO_US 5000
`define FR_TMO_CYC ((`FR_TMO_US * 1000) / `FR_CLK_NS)
`endif

// >>> design/framer_pkg.sv
// types and crc step of the binary telegram framer
// assumes framer_params.svh on the include path
`default_nettype none
`include "framer_params.svh"
package framer_pkg;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_ADDR = 3'h1, RX_LEN = 3'h2,
		RX_DATA = 3'h3, RX_CRCH = 3'h4, RX_CRCL = 3'h5
	} rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_SC = 3'h1, TX_LEN = 3'h2,
		TX_DATA = 3'h3, TX_CRCH = 3'h4, TX_CRCL = 3'h5
	} tx_state_t;
	typedef enum logic [1:0] {
		KIND_RSP = 2'h0, KIND_ACK = 2'h1, KIND_NAK = 2'h2
	} tx_kind_t;
	// received telegram events, all one-cycle pulses except the levels
	typedef struct packed {
		logic strobe;
		logic [7:0] data;
		logic done;
		logic crc_err;
		logic is_write;
		logic [7:0] addr;
		logic timeout;
	} rx_out_t;
	typedef struct packed {
		logic start;
		tx_kind_t kind;
		logic [7:0] len;
		logic [15:0] err;
	} tx_req_t;
	typedef struct packed {
		rx_state_t rx_st;
		logic [15:0] rx_crc;
		logic [7:0] rx_len;
		logic [7:0] rx_cnt;
		logic [7:0] rx_chk_hi;
		logic [15:0] tmo_cnt;
		rx_out_t rx_out;
		tx_state_t tx_st;
		tx_kind_t tx_kind;
		logic [7:0] tx_len;
		logic [7:0] tx_cnt;
		logic [15:0] tx_err;
		logic [15:0] tx_crc;
		logic [7:0] tx_byte;
		logic tx_next;
		logic tx_act;
	} state_t;

	// one table step: table[crc>>8] ^ (crc<<8) ^ byte, table built bitwise
	function automatic logic [15:0] crc_upd(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] t;
		t = {crc[15:8], 8'h00};
		for (int i = 0; i < 8; i++) begin
			t = t[15] ? ((t << 1) ^ `FR_CRC_POLY) : (t << 1);
		end
		return t ^ {crc[7:0], 8'h00} ^ {8'h00, b};
	endfunction : crc_upd
endpackage : framer_pkg
`default_nettype wire

// >>> test/serial_sink.sv
// byte sink standing for the serial transmitter beyond the framer
// assumes a byte is handed over on valid and ready at the rising edge
`default_nettype none
module serial_sink (
	input wire logic i_mclk, // system clock
	input wire logic i_slow, // 1: ready every other cycle
	input wire logic i_valid, // byte offered
	input wire logic [7:0] i_byte, // offered byte
	output logic o_ready // byte taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic ph = 1'b0;
	always @(negedge i_mclk) begin
		ph <= ~ph;
	end
	assign o_ready = i_slow ? ph : 1'b1;
	always @(posedge i_mclk) begin
		if (i_valid && o_ready) begin
			got.push_back(i_byte);
		end
	end
endmodule : serial_sink
`default_nettype wire

// >>> test/binary_telegram_framer_crc16_tb.sv
// self-checking bench of the telegram framer
// assumes serial_sink and framer_pkg compiled first
`default_nettype none
module binary_telegram_framer_crc16_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import framer_pkg::*;
	typedef logic [7:0] bytes_t[$];
	localparam int TMO = 20;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_rx_valid = 1'b0;
	logic [7:0] i_rx_byte = 8'h00;
	tx_req_t i_tx_req = '0;
	rx_out_t o_rx;
	logic o_tx_next, o_tx_busy, o_tx_valid, i_tx_ready;
	logic slow = 1'b0;
	logic [7:0] o_tx_byte;
	wire logic [7:0] i_tx_data;
	logic [7:0] rx_got[$];
	logic [7:0] rsp_d[0:255];
	int n_mismatch = 0;
	int compares = 0;
	int n_done = 0;
	int n_tmo = 0;
	int idx = 0;
	// ****************************************
	// instances, clock, monitors
	// ****************************************
	binary_telegram_framer_crc16 #(
		.TMO_CYCLES(TMO)
	) u_binary_telegram_framer_crc16 (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_rx_valid(i_rx_valid),
		.i_rx_byte(i_rx_byte), .o_rx(o_rx), .i_tx_req(i_tx_req),
		.i_tx_data(i_tx_data), .o_tx_next(o_tx_next), .o_tx_busy(o_tx_busy),
		.o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
		.i_tx_ready(i_tx_ready));
	serial_sink u_serial_sink (.i_mclk(i_mclk), .i_slow(slow),
		.i_valid(o_tx_valid), .i_byte(o_tx_byte), .o_ready(i_tx_ready));
	initial begin
		forever #50 i_mclk = ~i_mclk;
	end
	always @(negedge i_mclk) begin
		if (o_rx.strobe === 1'b1) rx_got.push_back(o_rx.data);
		if (o_rx.done === 1'b1) n_done++;
		if (o_rx.timeout === 1'b1) n_tmo++;
	end
	always @(negedge i_mclk) begin
		if (o_tx_next === 1'b1) idx <= idx + 1;
	end
	assign i_tx_data = rsp_d[idx[7:0]];
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] crc_tb(input bytes_t m);
		logic [15:0] c, t;
		c = 16'h0000;
		foreach (m[i]) begin
			t = {c[15:8], 8'h00};
			repeat (8) t = t[15] ? ((t << 1) ^ 16'h1021) : (t << 1);
			c = t ^ {c[7:0], 8'h00} ^ {8'h00, m[i]};
		end
		return c;
	endfunction : crc_tb
	task automatic report_and_stop();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : tick
	task automatic rx_send(input bytes_t b);
		foreach (b[i]) begin
			i_rx_valid = 1'b1;
			i_rx_byte = b[i];
			tick(1);
			i_rx_valid = 1'b0;
			tick(1);
		end
		tick(2);
	endtask : rx_send
	task automatic rx_case(input bytes_t b, input bytes_t d,
		input logic [7:0] ad, input logic wr, input logic err);
		int nd;
		nd = n_done;
		rx_got.delete();
		rx_send(b);
		chk(16'(n_done - nd), 16'h0001);
		chk(16'(rx_got.size()), 16'(d.size()));
		foreach (d[i]) chk(rx_got[i], d[i]);
		chk(o_rx.addr, ad);
		chk(o_rx.is_write, wr);
		chk(o_rx.crc_err, err);
	endtask : rx_case
	task automatic tx_case(input tx_kind_t k, input logic [7:0] ln,
		input logic [15:0] er, input bytes_t e);
		int w;
		u_serial_sink.got.delete();
		idx = 0;
		i_tx_req = '{start: 1'b1, kind: k, len: ln, err: er};
		tick(1);
		i_tx_req.kind = KIND_NAK;
		i_tx_req.err = 16'hFFFF;
		tick(1);
		i_tx_req.start = 1'b0;
		w = 0;
		while (o_tx_busy !== 1'b0 && w < 2000) begin
			tick(1);
			w++;
		end
		if (w == 2000) begin
			n_mismatch++;
			report_and_stop();
		end
		tick(2);
		chk(16'(u_serial_sink.got.size()), 16'(e.size()));
		foreach (e[i]) chk(u_serial_sink.got[i], e[i]);
	endtask : tx_case
	// ****************************************
	// scenarios
	// ****************************************
	bytes_t RD = {8'hA5, 8'h03, 8'h02, 8'h02, 8'hA8, 8'h05,
		8'hE1, 8'h46};
	bytes_t WD = {8'h07, 8'h6D, 8'h01, 8'h00, 8'h09, 8'h2E,
		8'h00, 8'h00, 8'h00};
	task automatic sc_read();
		rx_send({8'h05, 8'h13});
		rx_case(RD, {8'h02, 8'hA8, 8'h05}, 8'h03, 1'b0, 1'b0);
	endtask : sc_read
	task automatic sc_write();
		bytes_t b;
		b = {8'hC5, 8'h02, 8'h08, WD, 8'h95, 8'hD5};
		rx_case(b, WD, 8'h02, 1'b1, 1'b0);
		b[$] = 8'hD4;
		rx_case(b, WD, 8'h02, 1'b1, 1'b1);
	endtask : sc_write
	task automatic sc_timeout();
		int t;
		int nd;
		t = n_tmo;
		nd = n_done;
		rx_send({8'hA4, 8'h02, 8'h11});
		tick(TMO - 6);
		chk(16'(n_tmo - t), 16'h0000);
		tick(10);
		chk(16'(n_tmo - t), 16'h0001);
		chk(16'(n_done - nd), 16'h0000);
		rx_case(RD, {8'h02, 8'hA8, 8'h05}, 8'h03, 1'b0, 1'b0);
	endtask : sc_timeout
	task automatic sc_tx();
		logic [15:0] c;
		bytes_t e;
		slow = 1'b1;
		tx_case(KIND_ACK, 8'h00, 16'h0000,
			{8'h06, 8'h01, 8'h00, 8'h00, 8'hBA, 8'h87});
		c = crc_tb({8'h07, 8'h01, 8'h12, 8'h34});
		tx_case(KIND_NAK, 8'h00, 16'h1234, {8'h07, 8'h01, 8'h12, 8'h34,
			c[15:8], c[7:0]});
		slow = 1'b0;
		rsp_d[0:5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h2D};
		tx_case(KIND_RSP, 8'h05, 16'h0000, {8'h05, 8'h05, 8'hFF, 8'hFF,
			8'hFF, 8'hFF, 8'hFE, 8'h2D, 8'h07, 8'hB4});
		for (int i = 0; i < 256; i++) rsp_d[i] = 8'h00;
		e = {8'h05, 8'hFC};
		repeat (253) e.push_back(8'h00);
		c = crc_tb(e);
		e.push_back(c[15:8]);
		e.push_back(c[7:0]);
		tx_case(KIND_RSP, 8'hFF, 16'h0000, e);
	endtask : sc_tx
	initial begin
		tick(4);
		chk(o_tx_valid, 1'b0);
		i_sys_rst = 1'b0;
		sc_read();
		sc_write();
		sc_timeout();
		sc_tx();
		report_and_stop();
	end
endmodule : binary_telegram_framer_crc16_tb
`default_nettype wire
